// ===== hdl/gsr_cfg.svh
`ifndef GSR_CFG_SVH
`define GSR_CFG_SVH

// ==========================================================
// Register offsets (6-bit serial address)
`define GSR_ADDR_IDENT 6'h00
`define GSR_ADDR_TEMP_LO 6'h01
`define GSR_ADDR_TEMP_HI 6'h02
`define GSR_ADDR_RATEX_LO 6'h03
`define GSR_ADDR_RATEX_HI 6'h04
`define GSR_ADDR_RATEY_LO 6'h05
`define GSR_ADDR_RATEY_HI 6'h06
`define GSR_ADDR_STATUS 6'h0A
`define GSR_ADDR_CTRL_FIRST 6'h0B
`define GSR_ADDR_CTRL_FOURTH 6'h0E

// ==========================================================
// Field positions
`define GSR_FC_PULSE_SEL_BIT 3
`define GSR_F4_READY_EN_BIT 3
`define GSR_F4_OPEN_DRAIN_BIT 2
`define GSR_ST_LATCHED_BIT 0
`define GSR_ST_PULSE_BIT 1

// ==========================================================
// Reset values
`define GSR_CTRL_RESET 8'h00
// Identity value is arbitrary
`define GSR_IDENT_VALUE 8'h5C

// ==========================================================
// Timing
`define GSR_CLK_PERIOD_NS 8
`define GSR_CLK_HZ 125000000
`define GSR_PULSE_NS 75000
`define GSR_TEMP_RATE_HZ 70

`endif

// ===== hdl/gsr_pkg.sv
package gsr_pkg;

  // ==========================================================
  // Serial frame phases
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_CMD,
    SP_DATA
  } gsr_spi_phase_e;

  typedef logic [7:0] gsr_byte_t;

endpackage : gsr_pkg

// ===== hdl/gsr_pin_sync.sv
`timescale 1ns/10ps

// ==========================================================
// Three-stage pin filter
module gsr_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pinIn,
  output logic level
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  // First stage feeds only the second
  always_comb begin
    stage_next = {stage_reg[1:0], pinIn};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage_reg <= {3{RESET_LEVEL}};
      level_reg <= RESET_LEVEL;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule : gsr_pin_sync

// ===== hdl/gsr_readout.sv
`timescale 1ns/10ps
`include "gsr_cfg.svh"

// Functional notes
// [RULE1] Ready pin shows indications only while the enable bit is one.
// [RULE2] Host reads rate data each time the ready pin goes high.
// [RULE3] Ready pin is latched by default, pulsed when pulse select is one.
// [RULE4] Latched: set on new sample, cleared by high byte or status read.
// [RULE5] Pulsed: high 75 us per sample, reads have no effect.
// [RULE6] Pin is push-pull by default, open-drain when selected.
// [RULE7] Temperature is 12-bit left-justified two's complement in two bytes.
// [RULE8] Temperature code zero at 25 C, 0.0625 C per digit, about 70 Hz.
// [RULE9] Rate codes increase for counterclockwise rotation.
// [RULE10] Rate outputs are two's complement.
// [RULE11] Low four bits of the temperature word read zero.
module gsr_readout import gsr_pkg::*; #(
  parameter int PULSE_CYCLES =
    (`GSR_PULSE_NS + `GSR_CLK_PERIOD_NS - 1) / `GSR_CLK_PERIOD_NS,
  parameter int TEMP_PERIOD_CYCLES = `GSR_CLK_HZ / `GSR_TEMP_RATE_HZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial port pins
  input wire logic csN,
  input wire logic scl,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOeN,
  // Sample front end
  input wire logic sampleStrobe,
  input wire logic [15:0] rateXIn,
  input wire logic [15:0] rateYIn,
  input wire logic [11:0] tempCodeIn,
  // Ready pin
  output logic sampleReadyPin,
  output logic sampleReadyOeN
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int TW = $clog2(TEMP_PERIOD_CYCLES + 1);

  // ==========================================================
  // Elaboration checks
  if (PULSE_CYCLES < 1 || TEMP_PERIOD_CYCLES < 2) begin : gBad
    $error("gsr_readout: counts too small");
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Pin filters
  logic csS;
  logic sclS;
  logic sdiS;

  gsr_pin_sync #(.RESET_LEVEL(1'b1)) uCs (
    .ref_clk(ref_clk), .rst(rst), .pinIn(csN), .level(csS)
  );
  gsr_pin_sync #(.RESET_LEVEL(1'b1)) uScl (
    .ref_clk(ref_clk), .rst(rst), .pinIn(scl), .level(sclS)
  );
  gsr_pin_sync #(.RESET_LEVEL(1'b0)) uSdi (
    .ref_clk(ref_clk), .rst(rst), .pinIn(sdi), .level(sdiS)
  );

  // ==========================================================
  // State
  gsr_spi_phase_e phase_reg, phase_next;
  logic sclPrev_reg, sclPrev_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shiftIn_reg, shiftIn_next;
  gsr_byte_t shiftOut_reg, shiftOut_next;
  logic isRead_reg, isRead_next;
  logic autoInc_reg, autoInc_next;
  logic [5:0] addr_reg, addr_next;
  logic sdo_reg, sdo_next;
  logic sdoOeN_reg, sdoOeN_next;
  gsr_byte_t ctrlFirst_reg, ctrlFirst_next;
  gsr_byte_t ctrlFourth_reg, ctrlFourth_next;

  logic [15:0] rateX_reg, rateX_next;
  logic [15:0] rateY_reg, rateY_next;
  logic [15:0] temp_reg, temp_next;
  logic [TW-1:0] tempCnt_reg, tempCnt_next;
  logic latchReady_reg, latchReady_next;
  logic [PW-1:0] pulseCnt_reg, pulseCnt_next;
  logic pin_reg, pin_next;
  logic pinOeN_reg, pinOeN_next;

  logic readStrobe;
  logic [5:0] rdAddr;
  logic tempTick;
  logic pulseSel;
  logic readyEn;
  logic odSel;
  logic readyLevel;

  assign pulseSel = ctrlFirst_reg[`GSR_FC_PULSE_SEL_BIT];
  assign readyEn = ctrlFourth_reg[`GSR_F4_READY_EN_BIT];
  assign odSel = ctrlFourth_reg[`GSR_F4_OPEN_DRAIN_BIT];

  // Reading a rate high byte or the status register releases the latch
  function automatic logic clearsLatch(input logic [5:0] a);
    return (a == `GSR_ADDR_RATEX_HI) || (a == `GSR_ADDR_RATEY_HI) ||
      (a == `GSR_ADDR_STATUS); // [RULE4]
  endfunction : clearsLatch

  // Unmapped addresses read as zero
  function automatic gsr_byte_t regRead(input logic [5:0] a,
      input logic [15:0] tx, input logic [15:0] ty,
      input logic [15:0] tt, input gsr_byte_t st,
      input gsr_byte_t c1, input gsr_byte_t c4);
    case (a)
      `GSR_ADDR_IDENT: return `GSR_IDENT_VALUE;
      `GSR_ADDR_TEMP_LO: return tt[7:0];
      `GSR_ADDR_TEMP_HI: return tt[15:8];
      `GSR_ADDR_RATEX_LO: return tx[7:0];
      `GSR_ADDR_RATEX_HI: return tx[15:8];
      `GSR_ADDR_RATEY_LO: return ty[7:0];
      `GSR_ADDR_RATEY_HI: return ty[15:8];
      `GSR_ADDR_STATUS: return st;
      `GSR_ADDR_CTRL_FIRST: return c1;
      `GSR_ADDR_CTRL_FOURTH: return c4;
      default: return 8'h00;
    endcase
  endfunction : regRead

  // ==========================================================
  // Serial slave: sample on SCL rise, shift out on SCL fall
  always_comb begin
    logic [7:0] byteIn;
    gsr_byte_t status;
    byteIn = {shiftIn_reg[6:0], sdiS};
    status = 8'h00;
    status[`GSR_ST_LATCHED_BIT] = latchReady_reg;
    status[`GSR_ST_PULSE_BIT] = (pulseCnt_reg != '0);
    phase_next = phase_reg;
    sclPrev_next = sclS;
    bitCnt_next = bitCnt_reg;
    shiftIn_next = shiftIn_reg;
    shiftOut_next = shiftOut_reg;
    isRead_next = isRead_reg;
    autoInc_next = autoInc_reg;
    addr_next = addr_reg;
    sdo_next = sdo_reg;
    sdoOeN_next = sdoOeN_reg;
    ctrlFirst_next = ctrlFirst_reg;
    ctrlFourth_next = ctrlFourth_reg;
    readStrobe = 1'b0;
    rdAddr = addr_reg;
    if (csS) begin
      phase_next = SP_IDLE;
      bitCnt_next = 3'h0;
      sdoOeN_next = 1'b1;
    end else begin
      if (phase_reg == SP_IDLE) begin
        phase_next = SP_CMD;
      end
      if (sclS && !sclPrev_reg) begin
        shiftIn_next = byteIn;
        bitCnt_next = bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          case (phase_reg)
            SP_IDLE, SP_CMD: begin
              isRead_next = byteIn[7];
              autoInc_next = byteIn[6];
              addr_next = byteIn[5:0];
              rdAddr = byteIn[5:0];
              phase_next = SP_DATA;
              readStrobe = byteIn[7];
            end
            SP_DATA: begin
              if (!isRead_reg) begin
                if (addr_reg == `GSR_ADDR_CTRL_FIRST) begin
                  ctrlFirst_next = byteIn; // [RULE3]
                end
                if (addr_reg == `GSR_ADDR_CTRL_FOURTH) begin
                  ctrlFourth_next = byteIn; // [RULE1] [RULE6]
                end
              end
              if (autoInc_reg) begin
                addr_next = addr_reg + 6'h01;
              end
              rdAddr = addr_next;
              readStrobe = isRead_reg;
            end
            default: phase_next = SP_IDLE;
          endcase
          if (readStrobe) begin
            shiftOut_next = regRead(rdAddr, rateX_reg, rateY_reg,
              temp_reg, status, ctrlFirst_reg, ctrlFourth_reg);
          end
        end
      end else if (!sclS && sclPrev_reg && phase_reg == SP_DATA &&
          isRead_reg) begin
        sdo_next = shiftOut_reg[7];
        shiftOut_next = {shiftOut_reg[6:0], 1'b0};
        sdoOeN_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= SP_IDLE;
      sclPrev_reg <= 1'b1;
      bitCnt_reg <= 3'h0;
      shiftIn_reg <= 8'h00;
      shiftOut_reg <= 8'h00;
      isRead_reg <= 1'b0;
      autoInc_reg <= 1'b0;
      addr_reg <= 6'h00;
      sdo_reg <= 1'b0;
      sdoOeN_reg <= 1'b1;
      ctrlFirst_reg <= `GSR_CTRL_RESET;
      ctrlFourth_reg <= `GSR_CTRL_RESET;
    end else begin
      phase_reg <= phase_next;
      sclPrev_reg <= sclPrev_next;
      bitCnt_reg <= bitCnt_next;
      shiftIn_reg <= shiftIn_next;
      shiftOut_reg <= shiftOut_next;
      isRead_reg <= isRead_next;
      autoInc_reg <= autoInc_next;
      addr_reg <= addr_next;
      sdo_reg <= sdo_next;
      sdoOeN_reg <= sdoOeN_next;
      ctrlFirst_reg <= ctrlFirst_next;
      ctrlFourth_reg <= ctrlFourth_next;
    end
  end

  // ==========================================================
  // Sample capture, ready pin and temperature refresh
  // Temperature only moves on its own slow tick, so two byte reads
  // rarely straddle an update; no shadow copy is kept.
  assign tempTick = (tempCnt_reg == TW'(TEMP_PERIOD_CYCLES - 1));

  always_comb begin
    rateX_next = rateX_reg;
    rateY_next = rateY_reg;
    temp_next = temp_reg;
    tempCnt_next = tempTick ? '0 : tempCnt_reg + TW'(1);
    latchReady_next = latchReady_reg;
    pulseCnt_next = pulseCnt_reg;
    if (pulseCnt_reg != '0) begin
      pulseCnt_next = pulseCnt_reg - PW'(1); // [RULE5]
    end
    if (readStrobe && clearsLatch(rdAddr)) begin
      latchReady_next = 1'b0; // [RULE4]
    end
    if (sampleStrobe) begin
      rateX_next = rateXIn; // [RULE9] [RULE10]
      rateY_next = rateYIn; // [RULE9] [RULE10]
      latchReady_next = 1'b1; // [RULE4]
      pulseCnt_next = PW'(PULSE_CYCLES); // [RULE5]
    end
    if (tempTick) begin
      temp_next = {tempCodeIn, 4'h0}; // [RULE7] [RULE8] [RULE11]
    end
    readyLevel = readyEn && // [RULE1]
      (pulseSel ? (pulseCnt_reg != '0) : latchReady_reg); // [RULE3]
    // Open drain releases the pin for high and pulls it low otherwise
    pin_next = odSel ? 1'b0 : readyLevel; // [RULE6]
    pinOeN_next = odSel ? readyLevel : 1'b0; // [RULE6]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rateX_reg <= 16'h0000;
      rateY_reg <= 16'h0000;
      temp_reg <= 16'h0000;
      tempCnt_reg <= '0;
      latchReady_reg <= 1'b0;
      pulseCnt_reg <= '0;
      pin_reg <= 1'b0;
      pinOeN_reg <= 1'b0;
    end else begin
      rateX_reg <= rateX_next;
      rateY_reg <= rateY_next;
      temp_reg <= temp_next;
      tempCnt_reg <= tempCnt_next;
      latchReady_reg <= latchReady_next;
      pulseCnt_reg <= pulseCnt_next;
      pin_reg <= pin_next;
      pinOeN_reg <= pinOeN_next;
    end
  end

  assign sdo = sdo_reg;
  assign sdoOeN = sdoOeN_reg;
  assign sampleReadyPin = pin_reg;
  assign sampleReadyOeN = pinOeN_reg;

  // ==========================================================
  // Checks
  AST_PIN_GATED: assert property ( // [RULE1]
    !readyEn |=> (!sampleReadyPin && !sampleReadyOeN))
    else $error("ready pin active while disabled");

  AST_LATCH_SET: assert property ( // [RULE4]
    sampleStrobe |=> latchReady_reg)
    else $error("latch not set by new sample");

  AST_LATCH_CLEAR: assert property ( // [RULE4]
    (readStrobe && clearsLatch(rdAddr) && !sampleStrobe) |=> !latchReady_reg)
    else $error("latch not cleared by read");

  AST_LATCH_PIN: assert property ( // [RULE3]
    (latchReady_reg && readyEn && !pulseSel && !odSel) |=> sampleReadyPin)
    else $error("latched pin low while latch set");

  AST_PULSE_LOAD: assert property ( // [RULE5]
    sampleStrobe |=> (pulseCnt_reg == PW'(PULSE_CYCLES)))
    else $error("pulse length wrong");

  AST_PULSE_IGNORES_READ: assert property ( // [RULE5]
    (pulseCnt_reg > PW'(1) && !sampleStrobe) |=>
      (pulseCnt_reg == $past(pulseCnt_reg) - PW'(1)))
    else $error("pulse disturbed");

  AST_OPEN_DRAIN: assert property ( // [RULE6]
    (sampleReadyOeN |-> $past(odSel)) and ($past(odSel) |-> !sampleReadyPin))
    else $error("pin drive mode wrong");

  AST_TEMP_JUSTIFY: assert property ( // [RULE11]
    temp_reg[3:0] == 4'h0)
    else $error("temperature low nibble not zero");

  AST_TEMP_REFRESH: assert property ( // [RULE8]
    tempTick |=> (temp_reg == {$past(tempCodeIn), 4'h0}))
    else $error("temperature not refreshed");

  AST_RATE_CAPTURE: assert property ( // [RULE10]
    sampleStrobe |=> (rateX_reg == $past(rateXIn) &&
      rateY_reg == $past(rateYIn)))
    else $error("rate sample not captured");

endmodule : gsr_readout

// ===== bench/gsr_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// Serial host, mode 3, MSB first
module gsr_host_model (
  // Clock
  input wire logic ref_clk,
  // Serial port
  output logic csN,
  output logic scl,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOeN
);
  // Pin filters need 5 cycles per phase; 8 keeps margin
  localparam int HALF = 8;

  initial begin
    csN = 1'b1;
    scl = 1'b1;
    sdi = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // One command byte and one data byte
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    csN = 1'b0;
    cyc(HALF);
    for (int i = 15; i >= 0; i--) begin
      scl = 1'b0;
      sdi = sh[i];
      cyc(HALF);
      // Undriven line reads inverted, so it never matches by luck
      if (i < 8) rd = {rd[6:0], sdoOeN ? ~sdo : sdo};
      scl = 1'b1;
      cyc(HALF);
    end
    csN = 1'b1;
    sdi = ~sdi;
    cyc(2 * HALF);
  endtask : xfer
endmodule : gsr_host_model

// ===== bench/testbench.sv
`timescale 1ns/10ps
`include "gsr_cfg.svh"

`define CHK(nm, exp, got) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) begin \
      errTotal++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end

// ==========================================================
// Bench top
module testbench import gsr_pkg::*;;
  localparam int PULSE = 400;
  localparam int TEMP_PER = 20;
  localparam int LIMIT = 30000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wire logic csN, scl, sdi, sdo, sdoOeN;
  wire logic sampleReadyPin, sampleReadyOeN;
  logic sampleStrobe = 1'b0;
  logic [15:0] rateXIn = 16'h0000;
  logic [15:0] rateYIn = 16'h0000;
  logic [11:0] tempCodeIn = 12'h000;
  logic readyWire;
  gsr_byte_t rd;
  int errTotal = 0;
  int nChecks = 0;
  int cycCnt = 0;
  int hiCnt = 0;
  int unsigned seedVal;
  logic [5:0] clrAddr [3] = '{6'h04, 6'h06, 6'h0A};
  logic [11:0] tCode [4] = '{12'h000, 12'h800, 12'h7FF, 12'h5A3};

  // External pull-up on the ready pin
  assign readyWire = sampleReadyOeN ? 1'b1 : sampleReadyPin;

  always #4 ref_clk = ~ref_clk;

  gsr_readout #(.PULSE_CYCLES(PULSE), .TEMP_PERIOD_CYCLES(TEMP_PER)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .csN(csN), .scl(scl), .sdi(sdi),
    .sdo(sdo), .sdoOeN(sdoOeN), .sampleStrobe(sampleStrobe),
    .rateXIn(rateXIn), .rateYIn(rateYIn), .tempCodeIn(tempCodeIn),
    .sampleReadyPin(sampleReadyPin), .sampleReadyOeN(sampleReadyOeN));

  gsr_host_model i_host (
    .ref_clk(ref_clk), .csN(csN), .scl(scl), .sdi(sdi),
    .sdo(sdo), .sdoOeN(sdoOeN));

  task automatic results();
    $display("Checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  always @(posedge ref_clk) begin
    cycCnt++;
    if (sampleReadyPin === 1'b1) hiCnt++;
    if (cycCnt == LIMIT) begin
      errTotal++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic rdReg(input logic [5:0] a);
    i_host.xfer({2'b10, a}, 8'h00, rd);
  endtask : rdReg

  task automatic wrReg(input logic [5:0] a, input gsr_byte_t d);
    gsr_byte_t dummy;
    i_host.xfer({2'b00, a}, d, dummy);
  endtask : wrReg

  // Strobe lands at edge 0, pin settles after edge 1
  task automatic strobe(input logic [15:0] x, input logic [15:0] y);
    rateXIn = x;
    rateYIn = y;
    sampleStrobe = 1'b1;
    cyc(1);
    sampleStrobe = 1'b0;
    cyc(2);
  endtask : strobe

  function automatic gsr_byte_t expReg(input logic [5:0] a);
    case (a)
      6'h01: return {tempCodeIn[3:0], 4'h0};
      6'h02: return tempCodeIn[11:4];
      6'h03: return rateXIn[7:0];
      6'h04: return rateXIn[15:8];
      6'h05: return rateYIn[7:0];
      6'h06: return rateYIn[15:8];
      6'h0A: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : expReg

  initial begin
    seedVal = $urandom(32'hDF2E0F19);
    cyc(2);
    rst = 1'b0;
    `CHK("readyOeN", 1'b0, sampleReadyOeN);
    cyc(8);
    rdReg(`GSR_ADDR_CTRL_FIRST);
    `CHK("firstCtrl", 8'h00, rd);
    rdReg(`GSR_ADDR_CTRL_FOURTH);
    `CHK("fourthCtrl", 8'h00, rd);
    strobe(16'($urandom), 16'($urandom));
    `CHK("readyOff", 1'b0, sampleReadyPin);
    wrReg(`GSR_ADDR_CTRL_FOURTH, 8'h08);
    rdReg(`GSR_ADDR_CTRL_FOURTH);
    `CHK("fourthCtrl", 8'h08, rd);
    rdReg(6'h07);
    `CHK("unmapped", 8'h00, rd);
    // Latched mode, each clearing read; rates read after each rise
    for (int i = 0; i < 3; i++) begin
      strobe((i == 0) ? 16'h8000 : 16'($urandom),
        (i == 1) ? 16'h7FFF : 16'($urandom));
      `CHK("readySet", 1'b1, sampleReadyPin);
      rdReg(6'h03);
      `CHK("rateLow", expReg(6'h03), rd);
      `CHK("readyHeld", 1'b1, sampleReadyPin);
      rdReg(clrAddr[i]);
      `CHK("clearRead", expReg(clrAddr[i]), rd);
      `CHK("readyClr", 1'b0, sampleReadyPin);
    end
    strobe(16'($urandom), 16'($urandom));
    wrReg(`GSR_ADDR_CTRL_FOURTH, 8'h00);
    `CHK("readyDisabled", 1'b0, sampleReadyPin);
    rdReg(`GSR_ADDR_STATUS);
    wrReg(`GSR_ADDR_CTRL_FOURTH, 8'h08);
    wrReg(`GSR_ADDR_CTRL_FIRST, 8'h08);
    // Pulsed: a clearing read inside the pulse has no effect
    hiCnt = 0;
    strobe(16'($urandom), 16'($urandom));
    rdReg(6'h04);
    `CHK("pulseRead", expReg(6'h04), rd);
    `CHK("pulseHeld", 1'b1, sampleReadyPin);
    for (int k = 0; k < PULSE && sampleReadyPin === 1'b1; k++) cyc(1);
    cyc(1);
    `CHK("pulseLen", PULSE, hiCnt);
    // Open drain in latched mode
    wrReg(`GSR_ADDR_CTRL_FIRST, 8'h00);
    wrReg(`GSR_ADDR_CTRL_FOURTH, 8'h0C);
    rdReg(`GSR_ADDR_STATUS);
    `CHK("odIdle", 1'b0, readyWire);
    `CHK("odDriveLow", 1'b0, sampleReadyOeN);
    strobe(16'($urandom), 16'($urandom));
    `CHK("odHigh", 1'b1, readyWire);
    `CHK("odPinLow", 1'b0, sampleReadyPin);
    rdReg(`GSR_ADDR_STATUS);
    `CHK("odClr", 1'b0, readyWire);
    // Temperature corners then a random code
    tCode[3] = 12'($urandom);
    for (int i = 0; i < 4; i++) begin
      tempCodeIn = tCode[i];
      cyc(2 * TEMP_PER + 4);
      rdReg(`GSR_ADDR_TEMP_LO);
      `CHK("tempLow", expReg(6'h01), rd);
      rdReg(`GSR_ADDR_TEMP_HI);
      `CHK("tempHigh", expReg(6'h02), rd);
    end
    results();
  end
endmodule : testbench
